/* File: ecc_error_count_and_event_irq.sv */
// ECC error counter and open-drain event output of the flash device
// Function
// - 16-bit counter counts 1-bit and 2-bit errors
// - Only main array errors are counted
// - Counter counts only during array reads
// - Counter saturates at all ones
// - Burst keeps counting until chip select high
// - One count per unit per transaction
// - Multi-programmed unit without 2-bit detection: uncounted
// - Counter clears on every reset and clear
// - Count readable on octal and single-lane buses
// - Event output low on any enabled event
// - Output idles high; config enables and selects
// - Status records every enabled event since clear
// - Output only released, never driven high
// - Config bit 15 disables and releases output
// - Write one clears; low until all cleared
// - Clear ECC clears ECC status, keeps enables
// - Hardware and CS resets release output; hard resets disable all
// - Config and status reached over octal only
// - Data unit is an aligned 16-byte block
// - Config four bit 3 enables 2-bit detection
`include "ecc_irq_cfg.svh"

module ecc_error_count_and_event_irq
  import ecc_irq_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        cs_n_pin,
  input  wire logic        link_clk_pin,
  input  wire logic        hw_reset_n_pin,
  input  wire logic        cs_sig_reset,
  input  wire logic        sw_reset,
  input  wire logic        dev_busy,
  input  wire logic        det2_enable,
  input  wire logic        cmd_valid,
  input  wire cmd_t        cmd,
  input  wire logic        cmd_octal,
  input  wire logic [31:0] cmd_addr,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        unit_valid,
  input  wire logic        unit_err1,
  input  wire logic        unit_err2,
  input  wire logic        unit_main,
  input  wire logic        unit_multi_prog,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  output logic             int_n_o,
  output logic             int_n_oe
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic cs_n_meta_q;
  logic cs_n_sync_q;
  logic lclk_meta_q;
  logic lclk_sync_q;
  logic lclk_prev_q;
  logic hwr_meta_q;
  logic hwr_sync_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cs_n_meta_q <= 1'b1;
      cs_n_sync_q <= 1'b1;
    end else begin
      cs_n_meta_q <= cs_n_pin;
      cs_n_sync_q <= cs_n_meta_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lclk_meta_q <= 1'b0;
      lclk_sync_q <= 1'b0;
      lclk_prev_q <= 1'b0;
    end else begin
      lclk_meta_q <= link_clk_pin;
      lclk_sync_q <= lclk_meta_q;
      lclk_prev_q <= lclk_sync_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hwr_meta_q <= 1'b1;
      hwr_sync_q <= 1'b1;
    end else begin
      hwr_meta_q <= hw_reset_n_pin;
      hwr_sync_q <= hwr_meta_q;
    end
  end

  logic lclk_rise;
  logic hw_rst;
  logic hard_rst;
  logic out_rst;

  assign lclk_rise = lclk_sync_q && !lclk_prev_q;
  assign hw_rst    = !hwr_sync_q;
  assign hard_rst  = hw_rst;
  assign out_rst   = hw_rst || cs_sig_reset;

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  logic cmd_take;
  logic do_array_rd;
  logic do_rd_count;
  logic do_rd_cfg;
  logic do_rd_stat;
  logic do_wr_cfg;
  logic do_wr_stat;
  logic do_clr_ecc;

  function automatic logic is_cmd(input cmd_t c, input cmd_t want);
    is_cmd = (c == want);
  endfunction : is_cmd

  assign cmd_take    = cmd_valid && !cs_n_sync_q;
  assign do_array_rd = cmd_take && is_cmd(cmd, CMD_ARRAY_READ);
  assign do_rd_count = cmd_take && is_cmd(cmd, CMD_READ_COUNT);
  assign do_rd_cfg   = cmd_take && cmd_octal && is_cmd(cmd, CMD_READ_CFG);
  assign do_rd_stat  = cmd_take && cmd_octal && is_cmd(cmd, CMD_READ_STATUS);
  assign do_wr_cfg   = cmd_take && cmd_octal && is_cmd(cmd, CMD_WRITE_CFG);
  assign do_wr_stat  = cmd_take && cmd_octal && is_cmd(cmd, CMD_WRITE_STATUS);
  assign do_clr_ecc  = cmd_take && is_cmd(cmd, CMD_CLEAR_ECC);

  // ------------------------------------------------------------
  // Transaction state
  // ------------------------------------------------------------
  txn_state_t txn_q;
  logic       octal_q;

  always_ff @(posedge ref_clk) begin
    if (srst || hard_rst || cs_sig_reset || sw_reset) begin
      txn_q <= ST_IDLE;
    end else begin
      case (txn_q)
        ST_IDLE: begin
          if (do_array_rd) begin
            txn_q <= ST_ARRAY_READ;
          end else if (cmd_take) begin
            txn_q <= ST_OTHER_TXN;
          end
        end
        ST_ARRAY_READ: begin
          if (cs_n_sync_q) begin
            txn_q <= ST_IDLE;
          end
        end
        ST_OTHER_TXN: begin
          if (cs_n_sync_q) begin
            txn_q <= ST_IDLE;
          end
        end
        default: begin
          txn_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      octal_q <= 1'b0;
    end else if (do_array_rd) begin
      octal_q <= cmd_octal;
    end
  end

  // ------------------------------------------------------------
  // Data unit tracking on link clock edges
  // ------------------------------------------------------------
  logic [`UNIT_IDX_W-1:0] unit_idx_q;
  logic [7:0]             beat_q;
  logic [7:0]             unit_clks;

  assign unit_clks = octal_q ? `UNIT_CLKS_OCTAL : `UNIT_CLKS_SPI;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      unit_idx_q <= '0;
      beat_q     <= `BEAT_RESET;
    end else if (do_array_rd) begin
      unit_idx_q <= cmd_addr[31:`UNIT_SHIFT];
      beat_q     <= `BEAT_RESET;
    end else if (txn_q == ST_ARRAY_READ && !cs_n_sync_q && lclk_rise) begin
      if (beat_q == unit_clks - 8'h01) begin
        beat_q     <= `BEAT_RESET;
        unit_idx_q <= unit_idx_q + 28'h0000001;
      end else begin
        beat_q <= beat_q + 8'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // Error qualification
  // ------------------------------------------------------------
  logic in_read;
  logic det_off;
  logic err1_seen;
  logic err2_seen;
  logic count_hit;

  assign in_read   = (txn_q == ST_ARRAY_READ) && !cs_n_sync_q;
  assign det_off   = unit_multi_prog && !det2_enable;
  assign err1_seen = in_read && unit_valid && !det_off && unit_err1;
  assign err2_seen = in_read && unit_valid && !det_off && unit_err2 && det2_enable;
  assign count_hit = (err1_seen || err2_seen) && unit_main;

  ecc_evt_if ev ();

  assign ev.hit      = count_hit;
  assign ev.unit_idx = unit_idx_q;
  assign ev.new_txn  = do_array_rd;
  assign ev.clear    = hard_rst || cs_sig_reset || sw_reset || do_clr_ecc;

  ecc_err_counter u_counter (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ev      (ev.cnt)
  );

  // ------------------------------------------------------------
  // Configuration register
  // ------------------------------------------------------------
  logic [15:0] cfg_q;

  always_ff @(posedge ref_clk) begin
    if (srst || hard_rst) begin
      cfg_q <= `CFG_RESET;
    end else if (do_wr_cfg) begin
      cfg_q <= cmd_wdata;
    end
  end

  // ------------------------------------------------------------
  // Event sources and status register
  // ------------------------------------------------------------
  logic                busy_q;
  logic [`EVT_W-1:0]   evt;
  logic [`EVT_W-1:0]   evt_en;
  logic [`EVT_W-1:0]   stat_q;
  logic [`EVT_W-1:0]   stat_clr;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= dev_busy;
    end
  end

  always_comb begin
    evt                = '0;
    evt[`EVT_ECC1_BIT] = err1_seen;
    evt[`EVT_ECC2_BIT] = err2_seen;
    evt[`EVT_RDY_BIT]  = busy_q && !dev_busy;
  end

  assign evt_en = cfg_q[`EVT_W-1:0];

  always_comb begin
    stat_clr = '0;
    if (do_wr_stat) begin
      stat_clr = cmd_wdata[`EVT_W-1:0];
    end
    if (do_clr_ecc) begin
      stat_clr = stat_clr | `ECC_EVT_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || out_rst) begin
      stat_q <= `STATUS_RESET;
    end else begin
      stat_q <= (stat_q & ~stat_clr) | (evt & evt_en);
    end
  end

  // ------------------------------------------------------------
  // Open-drain event output
  // ------------------------------------------------------------
  logic int_oe_q;
  logic int_o_q;

  always_ff @(posedge ref_clk) begin
    if (srst || out_rst) begin
      int_oe_q <= 1'b0;
    end else begin
      int_oe_q <= !cfg_q[`CFG_OUT_DIS_BIT] && |(stat_q & evt_en);
    end
  end

  always_ff @(posedge ref_clk) begin
    int_o_q <= 1'b0;
  end

  assign int_n_o  = int_o_q;
  assign int_n_oe = int_oe_q;

  // ------------------------------------------------------------
  // Read answers
  // ------------------------------------------------------------
  logic [15:0] rd_data_q;
  logic        rd_valid_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= 16'h0000;
    end else begin
      rd_valid_q <= do_rd_count || do_rd_cfg || do_rd_stat;
      if (do_rd_count) begin
        rd_data_q <= ev.count;
      end else if (do_rd_cfg) begin
        rd_data_q <= cfg_q;
      end else if (do_rd_stat) begin
        rd_data_q <= {13'h0000, stat_q};
      end else begin
        rd_data_q <= 16'h0000;
      end
    end
  end

  assign rd_data  = rd_data_q;
  assign rd_valid = rd_valid_q;

endmodule : ecc_error_count_and_event_irq

/* File: ecc_irq_cfg.svh */
// Offsets, field positions, reset values and timing counts of the ECC event block
`ifndef ECC_IRQ_CFG_SVH
`define ECC_IRQ_CFG_SVH

`define COUNT_W          16
`define COUNT_RESET      16'h0000
`define COUNT_MAX        16'hffff
`define CFG_RESET        16'h8000
`define CFG_OUT_DIS_BIT  15
`define EVT_ECC1_BIT     0
`define EVT_ECC2_BIT     1
`define EVT_RDY_BIT      2
`define EVT_W            3
`define STATUS_RESET     3'h0
`define ECC_EVT_MASK     3'h3
`define UNIT_BYTES       16
`define UNIT_SHIFT       4
`define UNIT_IDX_W       28
`define UNIT_CLKS_OCTAL  8'h08
`define UNIT_CLKS_SPI    8'h80
`define BEAT_RESET       8'h00

`endif

/* File: ecc_irq_pkg.sv */
// Types shared by the ECC error counter and event output logic
package ecc_irq_pkg;

  typedef enum logic [2:0] {
    CMD_ARRAY_READ,
    CMD_READ_COUNT,
    CMD_READ_CFG,
    CMD_READ_STATUS,
    CMD_WRITE_CFG,
    CMD_WRITE_STATUS,
    CMD_CLEAR_ECC,
    CMD_OTHER
  } cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARRAY_READ,
    ST_OTHER_TXN
  } txn_state_t;

endpackage : ecc_irq_pkg

/* File: ecc_evt_if.sv */
// Error hits passed from the transaction logic to the error counter
interface ecc_evt_if;
  logic        hit;
  logic [27:0] unit_idx;
  logic        new_txn;
  logic        clear;
  logic [15:0] count;

  modport src (output hit, output unit_idx, output new_txn, output clear, input count);
  modport cnt (input hit, input unit_idx, input new_txn, input clear, output count);
endinterface : ecc_evt_if

/* File: ecc_err_counter.sv */
// Saturating ECC error counter with one count per data unit per transaction
`include "ecc_irq_cfg.svh"

module ecc_err_counter
  import ecc_irq_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic srst,
  ecc_evt_if.cnt    ev
);

  logic [`COUNT_W-1:0]    count_q;
  logic [`UNIT_IDX_W-1:0] last_idx_q;
  logic                   last_vld_q;
  logic                   take;

  function automatic logic [`COUNT_W-1:0] sat_inc(input logic [`COUNT_W-1:0] v);
    sat_inc = (v == `COUNT_MAX) ? v : v + 16'h0001;
  endfunction : sat_inc

  // Same unit twice in one transaction counts once
  assign take = ev.hit && !(last_vld_q && (last_idx_q == ev.unit_idx));

  always_ff @(posedge ref_clk) begin
    if (srst || ev.clear) begin
      count_q <= `COUNT_RESET;
    end else if (take) begin
      count_q <= sat_inc(count_q);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst || ev.clear || ev.new_txn) begin
      last_vld_q <= 1'b0;
      last_idx_q <= '0;
    end else if (take) begin
      last_vld_q <= 1'b1;
      last_idx_q <= ev.unit_idx;
    end
  end

  assign ev.count = count_q;

endmodule : ecc_err_counter

/* File: ecc_irq_properties.sv */
// Port-level checks of the ECC counter and event output block
module ecc_irq_properties
  import ecc_irq_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        cs_n_pin,
  input wire logic        hw_reset_n_pin,
  input wire logic        cs_sig_reset,
  input wire logic        cmd_valid,
  input wire cmd_t        cmd,
  input wire logic        cmd_octal,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] rd_data,
  input wire logic        rd_valid,
  input wire logic        int_n_o,
  input wire logic        int_n_oe
);
  logic [2:0] cs_hist_q;
  logic [2:0] hw_hist_q;
  logic       sel_ok;

  // Pin history, covers the two-stage sync
  always_ff @(posedge ref_clk) begin
    cs_hist_q <= {cs_hist_q[1:0], cs_n_pin};
    hw_hist_q <= {hw_hist_q[1:0], hw_reset_n_pin};
  end
  assign sel_ok = (cs_hist_q == 3'h0) && (hw_hist_q == 3'h7) && !cs_n_pin;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_cfg_off;
    cmd_valid && cmd == CMD_WRITE_CFG && cmd_octal && cmd_wdata[15] && sel_ok;
  endsequence
  sequence s_count_rd;
    cmd_valid && cmd == CMD_READ_COUNT && sel_ok;
  endsequence

  a_oe_only_low: assert property (int_n_oe |-> int_n_o == 1'b0)
    else $error("event pin driven high");
  a_idle_rd_zero: assert property (!rd_valid |-> rd_data == 16'h0000)
    else $error("read data without answer");
  a_rd_has_cause: assert property (rd_valid |-> $past(cmd_valid))
    else $error("answer without command");
  a_count_answer: assert property (s_count_rd |=> rd_valid)
    else $error("count read unanswered");
  a_spi_cfg_refused: assert property (cmd_valid && !cmd_octal &&
    cmd inside {CMD_READ_CFG, CMD_READ_STATUS} |=> !rd_valid)
    else $error("single lane config read answered");
  a_cfg_off_release: assert property (s_cfg_off |-> ##2 !int_n_oe)
    else $error("output kept after disable");
  a_cs_reset_release: assert property (cs_sig_reset |=> !int_n_oe)
    else $error("output kept after cs reset");
  a_hw_reset_release: assert property ($fell(hw_reset_n_pin) |-> ##[1:4] !int_n_oe)
    else $error("output kept after hw reset");
endmodule : ecc_irq_properties

bind ecc_error_count_and_event_irq ecc_irq_properties u_props (
  .ref_clk, .srst, .cs_n_pin, .hw_reset_n_pin, .cs_sig_reset, .cmd_valid, .cmd,
  .cmd_octal, .cmd_wdata, .rd_data, .rd_valid, .int_n_o, .int_n_oe);

/* File: host_link_model.sv */
// Host side: chip select, framed link clock and event line pull-up
module host_link_model (
  input  wire logic frame_on,
  input  wire logic int_n_o,
  input  wire logic int_n_oe,
  output logic      cs_n_pin,
  output logic      link_clk_pin,
  output wire logic int_line
);
  timeunit 1ns;
  timeprecision 100ps;
  assign cs_n_pin = !frame_on;
  assign int_line = int_n_oe ? int_n_o : 1'b1;
  // Link clock runs only inside a frame
  initial begin
    link_clk_pin = 1'b0;
    #7;
    forever begin
      #24;
      link_clk_pin = frame_on ? ~link_clk_pin : 1'b0;
    end
  end
endmodule : host_link_model

/* File: ecc_error_count_and_event_irq_tb.sv */
// Self-checking bench of the ECC counter and event output block
module ecc_error_count_and_event_irq_tb
  import ecc_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 0, srst = 1, hw_reset_n_pin = 1, cs_sig_reset = 0, sw_reset = 0;
  logic dev_busy = 0, det2_enable = 0, cmd_valid = 0, cmd_octal = 0, unit_valid = 0;
  logic unit_err1 = 0, unit_err2 = 0, unit_main = 0, unit_multi_prog = 0, frame_on = 0;
  cmd_t        cmd = CMD_OTHER;
  logic [31:0] cmd_addr = 32'h0, addr;
  logic [15:0] cmd_wdata = 16'h0, rd_data, rv;
  logic        rd_valid, int_n_o, int_n_oe, cs_n_pin, link_clk_pin;
  wire         int_line;
  int          fail_count = 0, check_count = 0, m_cnt = 0, m_cfg = 32768, m_stat = 0, cu, u_clks;
  int          seen_u[$];

  always #2.5 ref_clk = ~ref_clk;

  ecc_error_count_and_event_irq dut (.ref_clk, .srst, .cs_n_pin, .link_clk_pin,
    .hw_reset_n_pin, .cs_sig_reset, .sw_reset, .dev_busy, .det2_enable, .cmd_valid, .cmd,
    .cmd_octal, .cmd_addr, .cmd_wdata, .unit_valid, .unit_err1, .unit_err2, .unit_main,
    .unit_multi_prog, .rd_data, .rd_valid, .int_n_o, .int_n_oe);
  host_link_model host (.frame_on, .int_n_o, .int_n_oe, .cs_n_pin, .link_clk_pin, .int_line);

  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic go(input cmd_t c, input logic oct, input logic [15:0] w);
    @(posedge ref_clk) #1;
    cmd_valid = 1; cmd = c; cmd_octal = oct; cmd_addr = addr; cmd_wdata = w;
    @(posedge ref_clk) #1;
    rv = rd_valid ? rd_data : 16'hdead;
    cmd_valid = 0;
  endtask : go

  task automatic ev_chk;
    repeat (3) @(posedge ref_clk);
    #1 chk({15'h0, int_line}, {15'h0, !(!m_cfg[15] && (m_stat & m_cfg & 7) != 0)});
  endtask : ev_chk

  task automatic frame;
    @(posedge ref_clk) #1 frame_on = 0;
    repeat (4) @(posedge ref_clk);
    #1 frame_on = 1;
    repeat (4) @(posedge ref_clk);
  endtask : frame

  // Array read opens its own chip-select frame
  task automatic arr(input logic oct);
    frame;
    go(CMD_ARRAY_READ, oct, 16'h0);
    cu = addr[31:4];
    u_clks = oct ? 8 : 128;
    seen_u.delete();
    repeat (4) @(posedge link_clk_pin);
  endtask : arr

  task automatic next_unit;
    repeat (u_clks) @(posedge link_clk_pin);
    cu++;
  endtask : next_unit

  task automatic unit(input logic m, input logic e1, input logic e2, input logic mp);
    @(posedge ref_clk) #1;
    unit_valid = 1; unit_main = m; unit_err1 = e1; unit_err2 = e2; unit_multi_prog = mp;
    @(posedge ref_clk) #1 unit_valid = 0;
    if ((e1 || (e2 && det2_enable)) && !(mp && !det2_enable)) begin
      if (m && !(cu inside {seen_u})) begin
        seen_u.push_back(cu);
        if (m_cnt < 32'hffff) m_cnt++;
      end
      m_stat |= m_cfg & (2 * (e2 && det2_enable) + e1);
    end
  endtask : unit

  task automatic busy_done;
    @(posedge ref_clk) #1 dev_busy = 1;
    @(posedge ref_clk) #1 dev_busy = 0;
    m_stat |= m_cfg & 4;
  endtask : busy_done

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    void'($urandom(40));
    addr = $urandom;
    repeat (16) @(posedge ref_clk);
    #1 srst = 0;
    frame;
    go(CMD_READ_COUNT, 0, 16'h0); chk(rv, m_cnt[15:0]);
    go(CMD_READ_CFG, 1, 16'h0); chk(rv, m_cfg[15:0]);
    go(CMD_WRITE_CFG, 1, 16'h0003); m_cfg = 3;
    go(CMD_WRITE_CFG, 0, 16'h8000);
    go(CMD_READ_CFG, 0, 16'h0); chk(rv, 16'hdead);
    go(CMD_READ_CFG, 1, 16'h0); chk(rv, m_cfg[15:0]);
    det2_enable = 1;
    arr(1);
    unit(1, 1, 0, 0); unit(1, 1, 0, 0);
    next_unit; unit(0, 0, 1, 0);
    next_unit; unit(1, 0, 1, 0);
    det2_enable = 0;
    next_unit; unit(1, 1, 0, 1); unit(1, 0, 1, 0);
    ev_chk;
    frame;
    go(CMD_READ_COUNT, 1, 16'h0); chk(rv, m_cnt[15:0]);
    arr(1);
    unit(1, 1, 0, 0);
    frame;
    go(CMD_READ_COUNT, 0, 16'h0); chk(rv, m_cnt[15:0]);
    go(CMD_READ_COUNT, 1, 16'h0); chk(rv, m_cnt[15:0]);
    go(CMD_READ_STATUS, 1, 16'h0); chk(rv, m_stat[15:0]);
    go(CMD_WRITE_CFG, 1, 16'h0007); m_cfg = 7;
    busy_done; ev_chk;
    go(CMD_WRITE_STATUS, 1, 16'h0001); m_stat &= ~1; ev_chk;
    go(CMD_CLEAR_ECC, 1, 16'h0); m_stat &= ~3; ev_chk;
    m_cnt = 0;
    go(CMD_READ_COUNT, 1, 16'h0); chk(rv, m_cnt[15:0]);
    go(CMD_READ_CFG, 1, 16'h0); chk(rv, m_cfg[15:0]);
    go(CMD_WRITE_CFG, 1, 16'h8007); m_cfg = 32775; ev_chk;
    go(CMD_WRITE_CFG, 1, 16'h0007); m_cfg = 7; ev_chk;
    go(CMD_WRITE_STATUS, 1, 16'h0004); m_stat = 0; ev_chk;
    // Single-lane burst: a unit spans more link clocks
    arr(0); unit(1, 1, 0, 0);
    repeat (8) @(posedge link_clk_pin);
    unit(1, 1, 0, 0);
    next_unit; unit(1, 1, 0, 0);
    go(CMD_READ_COUNT, 0, 16'h0); chk(rv, m_cnt[15:0]);
    @(posedge ref_clk) #1 sw_reset = 1;
    @(posedge ref_clk) #1 sw_reset = 0;
    m_cnt = 0;
    go(CMD_READ_COUNT, 1, 16'h0); chk(rv, m_cnt[15:0]);
    busy_done;
    @(posedge ref_clk) #1 cs_sig_reset = 1;
    @(posedge ref_clk) #1 cs_sig_reset = 0;
    m_stat = 0;
    ev_chk;
    go(CMD_READ_CFG, 1, 16'h0); chk(rv, m_cfg[15:0]);
    busy_done; ev_chk;
    // Event line not judged while hw reset is active
    @(posedge ref_clk) #1 hw_reset_n_pin = 0;
    repeat (4) @(posedge ref_clk);
    #1 hw_reset_n_pin = 1;
    repeat (4) @(posedge ref_clk);
    m_cfg = 32768;
    go(CMD_READ_CFG, 1, 16'h0); chk(rv, m_cfg[15:0]);
    close_out;
  end

  initial begin
    #60000;
    fail_count++;
    close_out;
  end
endmodule : ecc_error_count_and_event_irq_tb
